// ===== pbdm_map.sv
// Operation
// [RL1] Program counter is 13 bits, addressing 8k words of 14 bits.
// [RL2] Only program words 0000h to 07FFh are stored.
// [RL3] Fetches above 07FFh wrap into the stored 2k words.
// [RL4] Reset loads the program counter with 0000h.
// [RL5] A taken interrupt loads the program counter with 0004h.
// [RL6] Data memory has two banks, each with special and general locations.
// [RL7] Lowest 32 addresses of each bank decode to special registers.
// [RL8] 20h-7Fh in bank 0 and A0h-BFh in bank 1 are RAM.
// [RL9] F0h-FFh in bank 1 reach the same storage as 70h-7Fh.
// [RL10] Unimplemented data addresses read zero and ignore writes.
// [RL11] Bank select bit 0 picks bank 0, 1 picks bank 1.
// [RL12] Software keeps indirect and upper bank bits at zero.
// [RL13] General RAM holds 128 bytes, direct or via file select pointer.
// [RL14] Full data address is bank select bit above 7-bit direct field.
module pbdm_map
  import pbdm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire pbdm_pkg::pbdm_pc_op_t pc_op_i,
  input wire logic [12:0] pc_load_i,
  output logic [12:0] pc_o,
  input wire logic prog_we_i,
  input wire logic [12:0] prog_waddr_i,
  input wire logic [13:0] prog_wdata_i,
  output logic [13:0] instr_o,
  input wire logic bank_select_bit_i,
  input wire logic indirect_i,
  input wire logic [7:0] file_select_pointer_i,
  input wire pbdm_pkg::pbdm_data_req_t data_req_i,
  output logic [7:0] rdata_o,
  output pbdm_pkg::pbdm_sfr_req_t sfr_req_o,
  input wire logic [7:0] sfr_rdata_i
);

  import pbdm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Program counter

  logic [12:0] pc;
  logic [12:0] next_pc;

  // INC rolls over from 1FFFh to 0000h
  always_comb
  begin
    next_pc = pc;
    unique case (pc_op_i)
      PBDM_PC_HOLD: next_pc = pc;
      PBDM_PC_INC: next_pc = 13'(pc + 13'h0001);
      PBDM_PC_LOAD: next_pc = pc_load_i;
      PBDM_PC_INTR: next_pc = INT_VECTOR; // see [RL5]
    endcase
  end

  // Reset wins over any operation asked in the same cycle
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pc <= RESET_VECTOR; // see [RL4]
    end
    else
    begin
      pc <= next_pc; // see [RL1]
    end
  end

  assign pc_o = pc;

  ////////////////////////////////////////////////////////////////////////
  // Program storage, 2k words; upper PC bits ignored so fetches wrap

  logic [13:0] prog_mem [0:PROG_DEPTH-1]; // see [RL2]
  logic [13:0] instr;
  logic [13:0] next_instr;

  // Loader writes drop address bits 12:11, the same wrap as fetches
  always_ff @(posedge core_clk_i)
  begin
    if (prog_we_i)
    begin
      prog_mem[prog_waddr_i[PROG_IMPL_AW-1:0]] <= prog_wdata_i;
    end
  end

  // Fetch index drops the upper PC bits, so 0800h reads the word at 0000h
  always_comb
  begin
    next_instr = prog_mem[next_pc[PROG_IMPL_AW-1:0]]; // see [RL3]
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      instr <= 14'h0000;
    end
    else
    begin
      instr <= next_instr;
    end
  end

  assign instr_o = instr;

  ////////////////////////////////////////////////////////////////////////
  // Data address decode

  logic [7:0] full_addr;
  logic is_sfr;
  logic is_gpr;
  logic [6:0] gpr_idx;

  always_comb
  begin
    full_addr = {bank_select_bit_i, data_req_i.direct_addr}; // see [RL14], [RL11]
    // Indirect access takes the whole pointer; there is no indirect bank bit
    if (indirect_i)
    begin
      full_addr = file_select_pointer_i; // see [RL13]
    end
    is_sfr = (full_addr[6:0] <= SFR_LAST); // see [RL7], [RL6]
    // C0h-EFh match no range below and stay unmapped
    is_gpr = 1'b0;
    gpr_idx = 7'h00;
    if (full_addr >= BANK0_GPR_LO && full_addr <= BANK0_GPR_HI)
    begin
      is_gpr = 1'b1; // see [RL8]
      gpr_idx = full_addr[6:0];
    end
    else if (full_addr >= BANK1_GPR_LO && full_addr <= BANK1_GPR_HI)
    begin
      is_gpr = 1'b1; // see [RL8]
      gpr_idx = 7'(full_addr[6:0] - BANK1_GPR_LO[6:0] + BANK1_GPR_BASE);
    end
    else if (full_addr >= MIRROR_LO && full_addr <= MIRROR_HI)
    begin
      is_gpr = 1'b1; // see [RL9]
      gpr_idx = 7'(full_addr & MIRROR_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // General RAM, 128 bytes: 20h-7Fh at 20h-7Fh, A0h-BFh at 00h-1Fh

  logic [7:0] gpr_rdata;
  logic [6:0] gpr_ram_idx;
  logic gpr_we;

  // Bank 1 RAM folds onto indices 00h-1Fh, left free by the bank 0 special area
  always_comb
  begin
    gpr_ram_idx = gpr_idx;
    if (gpr_idx >= BANK1_GPR_BASE && full_addr[7] && !full_addr[6])
    begin
      gpr_ram_idx = 7'(gpr_idx - BANK1_GPR_BASE); // see [RL8]
    end
  end

  assign gpr_we = data_req_i.wr && is_gpr; // see [RL10]

  pbdm_ram #(
    .AW(GPR_AW),
    .DW(DATA_W)
  ) u_gpr (
    .core_clk_i(core_clk_i),
    .we_i(gpr_we),
    .waddr_i(gpr_ram_idx),
    .wdata_i(data_req_i.wdata),
    .raddr_i(gpr_ram_idx),
    .rdata_o(gpr_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Special register port and read data

  logic [7:0] next_rdata;
  logic [7:0] rdata;

  always_comb
  begin
    // Number and bank come straight from the full address
    sfr_req_o.sfr_sel = is_sfr;
    sfr_req_o.sfr_num = 5'(full_addr & SFR_NUM_MASK);
    sfr_req_o.sfr_bank = full_addr[7];
    sfr_req_o.sfr_rd = data_req_i.rd && is_sfr;
    sfr_req_o.sfr_wr = data_req_i.wr && is_sfr;
    sfr_req_o.sfr_wdata = data_req_i.wdata;
  end

  always_comb
  begin
    // Zero unless a read hits a mapped location
    next_rdata = 8'h00; // see [RL10]
    if (data_req_i.rd && is_sfr)
    begin
      next_rdata = sfr_rdata_i;
    end
    else if (data_req_i.rd && is_gpr)
    begin
      next_rdata = gpr_rdata;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  assign rdata_o = rdata;

endmodule

// ===== pbdm_pkg.sv
package pbdm_pkg;

  localparam int PC_W = 13;
  localparam int PROG_W = 14;
  localparam int PROG_IMPL_AW = 11;
  localparam int PROG_DEPTH = 2048;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] INT_VECTOR = 13'h0004;

  localparam int DATA_W = 8;
  localparam int DADDR_W = 8;
  localparam int DIRECT_W = 7;
  localparam int GPR_DEPTH = 128;
  localparam int GPR_AW = 7;
  localparam logic [6:0] SFR_LAST = 7'h1F;
  localparam logic [7:0] BANK0_GPR_LO = 8'h20;
  localparam logic [7:0] BANK0_GPR_HI = 8'h7F;
  localparam logic [7:0] BANK1_GPR_LO = 8'hA0;
  localparam logic [7:0] BANK1_GPR_HI = 8'hBF;
  localparam logic [7:0] MIRROR_LO = 8'hF0;
  localparam logic [7:0] MIRROR_HI = 8'hFF;
  localparam logic [7:0] MIRROR_MASK = 8'h7F;
  localparam logic [6:0] BANK1_GPR_BASE = 7'h60;
  localparam logic [7:0] SFR_NUM_MASK = 8'h1F;

  typedef enum logic [1:0] {
    PBDM_PC_HOLD,
    PBDM_PC_INC,
    PBDM_PC_LOAD,
    PBDM_PC_INTR
  } pbdm_pc_op_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [DIRECT_W-1:0] direct_addr;
    logic [DATA_W-1:0] wdata;
  } pbdm_data_req_t;

  typedef struct packed {
    logic sfr_sel;
    logic [4:0] sfr_num;
    logic sfr_bank;
    logic sfr_rd;
    logic sfr_wr;
    logic [DATA_W-1:0] sfr_wdata;
  } pbdm_sfr_req_t;

endpackage

// ===== pbdm_ram.sv
module pbdm_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic core_clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[raddr_i];

endmodule

// ===== pbdm_map_checker.sv
module pbdm_map_checker
  import pbdm_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire pbdm_pkg::pbdm_pc_op_t pc_op_i,
  input wire logic [12:0] pc_load_i,
  input wire logic [12:0] pc_o,
  input wire logic bank_select_bit_i,
  input wire logic indirect_i,
  input wire logic [7:0] file_select_pointer_i,
  input wire pbdm_pkg::pbdm_data_req_t data_req_i,
  input wire logic [7:0] rdata_o,
  input wire pbdm_pkg::pbdm_sfr_req_t sfr_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] a;
  logic rd;
  assign a = indirect_i ? file_select_pointer_i : {bank_select_bit_i, data_req_i.direct_addr};
  assign rd = data_req_i.rd;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_wr; data_req_i.wr && a[6:4] == 3'h7; endsequence
  sequence s_rd; rd && a[6:4] == 3'h7 && a[3:0] == $past(a[3:0]); endsequence
  property p_rst; disable iff (1'b0) !rst_n_i |=> pc_o == RESET_VECTOR; endproperty
  a_rst: assert property (p_rst) else $error("pc not cleared");
  property p_int; pc_op_i == PBDM_PC_INTR |=> pc_o == INT_VECTOR; endproperty
  a_int: assert property (p_int) else $error("bad entry");
  property p_ld; pc_op_i == PBDM_PC_LOAD |=> pc_o == $past(pc_load_i); endproperty
  a_ld: assert property (p_ld) else $error("bad load");
  property p_inc; pc_op_i == PBDM_PC_INC |=> pc_o == $past(pc_o) + 13'h1; endproperty
  a_inc: assert property (p_inc) else $error("bad step");
  property p_hld; pc_op_i == PBDM_PC_HOLD |=> $stable(pc_o); endproperty
  a_hld: assert property (p_hld) else $error("pc moved");
  property p_sfr; (rd || data_req_i.wr) && a[6:5] == 2'h0 |-> sfr_req_o.sfr_sel
    && sfr_req_o.sfr_num == a[4:0] && sfr_req_o.sfr_bank == a[7]; endproperty
  a_sfr: assert property (p_sfr) else $error("bad special decode");
  property p_sfw; (rd || data_req_i.wr) |-> sfr_req_o.sfr_rd == (rd && a[6:5] == 2'h0)
    && sfr_req_o.sfr_wr == (data_req_i.wr && a[6:5] == 2'h0)
    && sfr_req_o.sfr_wdata == data_req_i.wdata; endproperty
  a_sfw: assert property (p_sfw) else $error("bad special strobe");
  property p_un; rd && a inside {[8'hC0:8'hEF]} |=> rdata_o == 8'h00; endproperty
  a_un: assert property (p_un) else $error("hole not zero");
  property p_mir; s_wr ##1 s_rd |=> rdata_o == $past(data_req_i.wdata, 2); endproperty
  a_mir: assert property (p_mir) else $error("alias lost");
endmodule
bind pbdm_map pbdm_map_checker chk_u (.core_clk_i, .rst_n_i, .pc_op_i, .pc_load_i, .pc_o,
  .bank_select_bit_i, .indirect_i, .file_select_pointer_i, .data_req_i, .rdata_o, .sfr_req_o);

// ===== pbdm_sfr_model.sv
module pbdm_sfr_model
  import pbdm_pkg::*;
(
  input wire pbdm_pkg::pbdm_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] val;
  // Per-register pattern, inverted when no read is asked
  assign val = {sfr_req_i.sfr_bank, 2'h0, sfr_req_i.sfr_num} ^ 8'h5A;
  assign sfr_rdata_o = sfr_req_i.sfr_rd ? val : ~val;
endmodule

// ===== pbdm_map_tb_top.sv
module pbdm_map_tb_top;
  import pbdm_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i = '0, rst_n_i = '0, prog_we_i = '0, bank_select_bit_i = '0, indirect_i = '0;
  pbdm_pc_op_t pc_op_i = PBDM_PC_HOLD;
  logic [12:0] pc_load_i = '0, prog_waddr_i = '0, pc_o;
  logic [13:0] prog_wdata_i = '0, instr_o, pm [8];
  logic [7:0] file_select_pointer_i = '0, rdata_o, sfr_rdata_i, ram [256];
  pbdm_data_req_t data_req_i = '0;
  pbdm_sfr_req_t sfr_req_o;
  int failures = 0, total_checks = 0, cyc = 0;
  pbdm_map dut_u (.core_clk_i, .rst_n_i, .pc_op_i, .pc_load_i, .pc_o, .prog_we_i, .prog_waddr_i,
    .prog_wdata_i, .instr_o, .bank_select_bit_i, .indirect_i, .file_select_pointer_i,
    .data_req_i, .rdata_o, .sfr_req_o, .sfr_rdata_i);
  pbdm_sfr_model model_u (.sfr_req_i(sfr_req_o), .sfr_rdata_o(sfr_rdata_i));
  always #25 core_clk_i = ~core_clk_i;
  task stop_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [13:0] seen, input logic [13:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function logic [7:0] k(input logic [7:0] a);
    return a >= 8'hF0 ? a & 8'h7F : a;
  endfunction
  // One data access; the bank bit and direct field are scrambled when indirect
  task op(input logic rd, input logic wr, input logic ind, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] e;
    e = 8'h00;
    if (rd && a[6:5] == 2'h0) e = {a[7], 2'h0, a[4:0]} ^ 8'h5A;
    else if (rd && !(a inside {[8'hC0:8'hEF]})) e = ram[k(a)];
    else if (wr && a[6:5] != 2'h0 && !(a inside {[8'hC0:8'hEF]})) ram[k(a)] = d;
    data_req_i = '{rd, wr, ind ? 7'($urandom) : a[6:0], d};
    bank_select_bit_i = ind ? 1'($urandom) : a[7];
    indirect_i = ind;
    file_select_pointer_i = ind ? a : 8'($urandom);
    @(negedge core_clk_i);
    chk(rdata_o, e);
  endtask
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial
  begin
    logic r;
    void'($urandom(19801));
    repeat (16) @(negedge core_clk_i);
    chk(pc_o, 14'h0000);
    rst_n_i = 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      prog_we_i = 1'h1;
      prog_waddr_i = {2'($urandom), 11'(i)};
      prog_wdata_i = 14'($urandom);
      pm[i] = prog_wdata_i;
      @(negedge core_clk_i);
    end
    prog_we_i = 1'h0;
    for (int i = 0; i < 8; i++)
    begin
      pc_op_i = PBDM_PC_LOAD;
      pc_load_i = {2'($urandom), 11'(i)};
      @(negedge core_clk_i);
      chk(pc_o, pc_load_i);
      chk(instr_o, pm[i]);
    end
    pc_op_i = PBDM_PC_INTR;
    @(negedge core_clk_i);
    chk(instr_o, pm[4]);
    pc_op_i = PBDM_PC_INC;
    @(negedge core_clk_i);
    chk(pc_o, 14'h0005);
    pc_op_i = PBDM_PC_LOAD;
    pc_load_i = 13'h1FFF;
    @(negedge core_clk_i);
    pc_op_i = PBDM_PC_INC;
    @(negedge core_clk_i);
    chk(instr_o, pm[0]);
    pc_op_i = PBDM_PC_HOLD;
    for (int i = 0; i < 256; i++) op(1'h0, 1'h1, 1'h1, 8'(i), 8'($urandom));
    op(1'h0, 1'h1, 1'h0, 8'h70, 8'h55);
    op(1'h1, 1'h0, 1'h0, 8'hF0, 8'h00);
    op(1'h1, 1'h0, 1'h0, 8'hC5, 8'h00);
    repeat (300)
    begin
      r = 1'($urandom);
      op(r, !r, 1'($urandom), 8'($urandom), 8'($urandom));
    end
    // Leave non-zero state behind so the mid-run reset has work to do
    pc_op_i = PBDM_PC_LOAD;
    pc_load_i = 13'h0805;
    op(1'h1, 1'h0, 1'h0, 8'h85, 8'h00);
    chk(pc_o, 14'h0805);
    chk(instr_o, pm[5]);
    pc_op_i = PBDM_PC_HOLD;
    rst_n_i = 1'h0;
    @(negedge core_clk_i);
    chk(pc_o, 14'h0000);
    chk(instr_o, 14'h0000);
    chk(rdata_o, 8'h00);
    rst_n_i = 1'h1;
    pc_op_i = PBDM_PC_INTR;
    @(negedge core_clk_i);
    chk(pc_o, 14'h0004);
    chk(instr_o, pm[4]);
    chk(rdata_o, {1'h1, 2'h0, 5'h05} ^ 8'h5A);
    stop_test();
  end
endmodule
